// ==== design/axis_position_ratio_home.sv ====
// Per-axis position keeping, position/ratio queries, completion
// messages, ratio following and the final homing phase.
// Assumes a command parser ahead of it and a reply formatter and
// step generator behind it, all on i_clock.
`timescale 1ns/1ns
`include "axis_position_map.svh"

module axis_position_ratio_home
  import axis_position_pkg::*;
#(
  parameter logic [`TICK_COUNT_W-1:0] HOME_TICK_CYCLES =
    `TICK_COUNT_W'(`HOME_TICK_CYCLES)
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_resetn,
  input  wire logic                    i_cmd_valid,
  input  wire cmd_type                 i_cmd,
  input  wire logic [`AXIS_COUNT-1:0]  i_step_cw,
  input  wire logic [`AXIS_COUNT-1:0]  i_step_ccw,
  input  wire logic [`AXIS_COUNT-1:0]  i_moving,
  input  wire logic [`AXIS_COUNT-1:0]  i_moving_cw,
  input  wire logic [`AXIS_COUNT-1:0]  i_speed_mode,
  input  wire logic [`AXIS_COUNT-1:0]  i_move_done,
  input  wire logic [`AXIS_COUNT-1:0]  i_home_switch_input,
  output logic                         o_reply_valid,
  output reply_type                    o_reply,
  output logic [`AXIS_COUNT-1:0]       o_step_req,
  output logic [`AXIS_COUNT-1:0]       o_step_cw,
  output logic [`AXIS_COUNT-1:0]       o_homing,
  output logic [`AXIS_COUNT-1:0]       o_underflow
);

  ////////////////////////////////////////////////////////////////////
  // State of the whole block, one packed record

  typedef struct packed {
    logic [`AXIS_COUNT-1:0][`POS_W-1:0]   position;
    logic [`AXIS_COUNT-1:0]               underflow;
    logic [`AXIS_COUNT-1:0]               trigger_en;
    logic [`AXIS_COUNT-1:0]               done_pend;
    logic [`AXIS_COUNT-1:0][`RATIO_W-1:0] ratio_stored;
    logic [`AXIS_COUNT-1:0][`RATIO_W-1:0] ratio_active;
    logic [`AXIS_COUNT-1:0]               ratio_pend;
    logic [`AXIS_COUNT-1:0]               follow_en;
    logic [`AXIS_COUNT-1:0]               follow_opp;
    logic [`AXIS_COUNT-1:0][`RATIO_W-1:0] follow_phase;
    logic [`AXIS_COUNT-1:0]               home_dir_cw;
    logic [`AXIS_COUNT-1:0][1:0]          res_sel;
    home_state_type [`AXIS_COUNT-1:0]     home_state;
    logic [`TICK_COUNT_W-1:0]             tick_count;
    logic [`AXIS_COUNT-1:0]               switch_meta;
    logic [`AXIS_COUNT-1:0]               switch_sync;
    logic                                 reply_valid;
    reply_type                            reply;
    logic [`AXIS_COUNT-1:0]               step_req;
    logic [`AXIS_COUNT-1:0]               step_cw;
  } state_type;

  state_type state_q;
  state_type state_d;

  ////////////////////////////////////////////////////////////////////
  // Increment size for a resolution code

  function automatic logic [`WEIGHT_W-1:0] step_weight(
    input logic [1:0] sel
  );
    logic [`WEIGHT_W-1:0] w;
    w = `WEIGHT_RES_1;
    unique case (resolution_type'(sel))
      RES_1:   w = `WEIGHT_RES_1;
      RES_2:   w = `WEIGHT_RES_2;
      RES_10:  w = `WEIGHT_RES_10;
      RES_125: w = `WEIGHT_RES_125;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic                            tick;
    logic [`AXIS_COUNT-1:0]          own_step;
    logic [`AXIS_COUNT-1:0]          own_cw;
    logic [`AXIS_COUNT-1:0]          home_done;
    logic [`AXIS_COUNT-1:0]          ctl_step;
    logic [`AXIS_COUNT-1:0]          ctl_cw;
    logic [`AXIS_COUNT-1:0]          move_end;
    logic [`RATIO_W:0]               phase_sum;
    logic signed [`DELTA_W-1:0]      delta;
    logic signed [`DELTA_W-1:0]      sum;
    logic signed [`DELTA_W-1:0]      weight_s;
    logic [`CMD_VALUE_W-1:0]         rounded;
    logic                            ctl;
    logic                            query_now;
    tick      = 1'b0;
    own_step  = '0;
    own_cw    = '0;
    home_done = '0;
    ctl_step  = '0;
    ctl_cw    = '0;
    move_end  = '0;
    phase_sum = '0;
    delta     = '0;
    sum       = '0;
    weight_s  = '0;
    rounded   = '0;
    ctl       = 1'b0;
    query_now = 1'b0;
    state_d   = state_q;
    state_d.reply_valid = 1'b0;
    state_d.step_req    = '0;

    // Home switch pins cross in through two flops
    state_d.switch_meta = i_home_switch_input;
    state_d.switch_sync = state_q.switch_meta;

    // Sample divider, 256 ticks a second, free running
    if (state_q.tick_count == HOME_TICK_CYCLES - `TICK_COUNT_W'(1)) begin
      state_d.tick_count = '0;
      tick = 1'b1;
    end else begin
      state_d.tick_count = state_q.tick_count + `TICK_COUNT_W'(1);
    end

    // Final homing phase: test the switch, else move one increment
    for (int a = 0; a < `AXIS_COUNT; a++) begin
      if (state_q.home_state[a] == HOME_SEEK && tick) begin
        if (state_q.switch_sync[a]) begin
          state_d.home_state[a] = HOME_IDLE;
          home_done[a] = 1'b1;
        end else begin
          own_step[a] = 1'b1;
          own_cw[a]   = state_q.home_dir_cw[a];
        end
      end
    end

    // Steps a control axis makes, external or its own home steps; its follower steps are not counted
    for (int a = 0; a < `AXIS_COUNT; a++) begin
      ctl_step[a] = i_step_cw[a] | i_step_ccw[a] | own_step[a];
      ctl_cw[a]   = own_step[a] ? own_cw[a] : i_step_cw[a];
      move_end[a] = i_move_done[a] | home_done[a];
    end

    // Follower gets a step on each carry of its phase accumulator.
    // A carry that meets a home step of the follower is dropped; homing the follower ends following.
    for (int f = 0; f < `AXIS_COUNT; f++) begin
      ctl = ~1'(f);
      if (state_q.follow_en[f] && ctl_step[ctl]) begin
        phase_sum = {1'b0, state_q.follow_phase[f]}
                  + {1'b0, state_q.ratio_active[f]};
        state_d.follow_phase[f] = phase_sum[`RATIO_W-1:0];
        if (phase_sum[`RATIO_W] && !own_step[f]) begin
          own_step[f] = 1'b1;
          own_cw[f]   = ctl_cw[ctl] ^ state_q.follow_opp[f];
        end
      end
      // A deferred ratio takes over once the control move ends
      if (state_q.ratio_pend[f] && move_end[ctl]) begin
        state_d.ratio_active[f] = state_q.ratio_stored[f];
        state_d.ratio_pend[f]   = 1'b0;
      end
    end

    // Step requests go out to the step generator; acceleration and
    // profile are applied there per axis
    state_d.step_req = own_step;
    for (int a = 0; a < `AXIS_COUNT; a++) begin
      if (own_step[a]) begin
        state_d.step_cw[a] = own_cw[a];
      end
    end

    // Position accumulation from every issued step
    for (int a = 0; a < `AXIS_COUNT; a++) begin
      weight_s = `DELTA_W'(step_weight(state_q.res_sel[a]));
      delta = '0;
      if (i_step_cw[a]) delta = delta + weight_s;
      if (i_step_ccw[a]) delta = delta - weight_s;
      if (own_step[a] && own_cw[a]) delta = delta + weight_s;
      if (own_step[a] && !own_cw[a]) delta = delta - weight_s;
      sum = `DELTA_W'(state_q.position[a]) + delta;
      if (sum < 0) begin
        state_d.position[a]  = '0;
        state_d.underflow[a] = 1'b1;
      end else if (sum > `DELTA_W'(`POS_MAX)) begin
        state_d.position[a] = `POS_MAX;
      end else begin
        state_d.position[a] = sum[`POS_W-1:0];
      end
      if (home_done[a]) begin
        state_d.position[a]  = '0;
        state_d.underflow[a] = 1'b0;
      end
      // Completion message pends until the reply slot is free
      if (move_end[a] && state_q.trigger_en[a]) begin
        state_d.done_pend[a] = 1'b1;
      end
    end

    // Host commands
    if (i_cmd_valid) begin
      unique case (i_cmd.op)
        OP_SET_POS: begin
          rounded = i_cmd.value + `POS_ROUND_HALF;
          state_d.position[i_cmd.axis] =
            rounded[`POS_ROUND_BITS +: `POS_W];
          state_d.underflow[i_cmd.axis] = 1'b0;
        end
        OP_QUERY_POS: begin
          query_now = 1'b1;
          state_d.reply.kind  = REPLY_POS;
          state_d.reply.axis  = i_cmd.axis;
          state_d.reply.value = state_q.position[i_cmd.axis];
          if (!i_moving[i_cmd.axis]) begin
            state_d.reply.status = `STATUS_STOPPED;
          end else if (i_moving_cw[i_cmd.axis]) begin
            state_d.reply.status = `STATUS_CW;
          end else begin
            state_d.reply.status = `STATUS_CCW;
          end
        end
        OP_TRIGGER: begin
          // Enabling sends nothing now; disabling drops any pending
          state_d.trigger_en[i_cmd.axis] = i_cmd.plus;
          if (!i_cmd.plus) begin
            state_d.done_pend[i_cmd.axis] = 1'b0;
          end
        end
        OP_RATIO_LOAD: begin
          ctl = ~i_cmd.axis;
          state_d.ratio_stored[i_cmd.axis] =
            i_cmd.value[`RATIO_W-1:0];
          if (!i_moving[ctl] || i_speed_mode[ctl]) begin
            state_d.ratio_active[i_cmd.axis] =
              i_cmd.value[`RATIO_W-1:0];
            state_d.ratio_pend[i_cmd.axis] = 1'b0;
          end else begin
            state_d.ratio_pend[i_cmd.axis] = 1'b1;
          end
        end
        OP_RATIO_EN: begin
          // Keeps the active ratio, not ratio_stored; plus means same direction
          state_d.follow_en[i_cmd.axis]    = 1'b1;
          state_d.follow_opp[i_cmd.axis]   = ~i_cmd.plus;
          state_d.follow_phase[i_cmd.axis] = '0;
        end
        OP_RATIO_QUERY: begin
          query_now = 1'b1;
          state_d.reply.kind   = REPLY_RATIO;
          state_d.reply.axis   = i_cmd.axis;
          state_d.reply.status = `STATUS_STOPPED;
          state_d.reply.value  = state_q.ratio_stored[i_cmd.axis];
        end
        OP_HOME_DIR: begin
          state_d.home_dir_cw[i_cmd.axis] = i_cmd.plus;
        end
        OP_RESOLUTION: begin
          state_d.res_sel[i_cmd.axis] = i_cmd.value[1:0];
        end
        OP_HOME: begin
          state_d.home_state[i_cmd.axis] = HOME_SEEK;
          state_d.follow_en[i_cmd.axis]  = 1'b0;
        end
        OP_MOTION: begin
          state_d.follow_en[i_cmd.axis] = 1'b0;
        end
        OP_NOP: begin
        end
        // Codes above OP_MOTION are unused and ignored
        default: begin
        end
      endcase
    end

    // Queries own the reply slot; completion messages wait a cycle.
    // A completion pending from the same cycle keeps its set.
    if (query_now) begin
      state_d.reply_valid = 1'b1;
    end else if (state_q.done_pend[0] || state_q.done_pend[1]) begin
      state_d.reply_valid  = 1'b1;
      state_d.reply.kind   = REPLY_DONE;
      state_d.reply.axis   = ~state_q.done_pend[0];
      state_d.reply.status = `STATUS_STOPPED;
      state_d.reply.value  = '0;
      if (state_q.done_pend[0]) begin
        state_d.done_pend[0] = move_end[0] & state_q.trigger_en[0];
      end else begin
        state_d.done_pend[1] = move_end[1] & state_q.trigger_en[1];
      end
      if (i_cmd_valid && i_cmd.op == OP_TRIGGER && !i_cmd.plus) begin
        state_d.done_pend[i_cmd.axis] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register; full-step resolution and zero values after reset

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign o_reply_valid = state_q.reply_valid;
  assign o_reply       = state_q.reply;
  assign o_step_req    = state_q.step_req;
  assign o_step_cw     = state_q.step_cw;
  assign o_underflow   = state_q.underflow;
  always_comb begin
    for (int a = 0; a < `AXIS_COUNT; a++) begin
      o_homing[a] = (state_q.home_state[a] == HOME_SEEK);
    end
  end

endmodule

// ==== common/axis_position_map.svh ====
// Constants for the two-axis position, ratio and home block.
// Assumes a 20 MHz system clock; all counts derive from it.
`ifndef AXIS_POSITION_MAP_SVH
`define AXIS_POSITION_MAP_SVH

`define CLOCK_HZ          20000000
`define HOME_SAMPLE_HZ    256
`define HOME_TICK_CYCLES  (`CLOCK_HZ / `HOME_SAMPLE_HZ)
`define TICK_COUNT_W      17

`define AXIS_COUNT        2
`define POS_W             32
`define RATIO_W           32
`define CMD_VALUE_W       40
`define POS_ROUND_BITS    8
`define POS_ROUND_HALF    40'h00_0000_0080
`define POS_MAX           32'hffff_ffff
`define DELTA_W           36

// Position units (1/1024 step) moved per increment at each resolution
`define WEIGHT_RES_1      12'h400
`define WEIGHT_RES_2      12'h200
`define WEIGHT_RES_10     12'h066
`define WEIGHT_RES_125    12'h008
`define WEIGHT_W          12

// Status characters of a position reply
`define STATUS_STOPPED    8'h3d
`define STATUS_CW         8'h2b
`define STATUS_CCW        8'h2d

`endif

// ==== common/axis_position_pkg.sv ====
// Types shared by the position block and its surroundings.
// Assumes axis_position_map.svh is on the include path.
package axis_position_pkg;
  `include "axis_position_map.svh"

  typedef enum logic [3:0] {
    OP_NOP         = 4'h0,
    OP_SET_POS     = 4'h1,
    OP_QUERY_POS   = 4'h2,
    OP_TRIGGER     = 4'h3,
    OP_RATIO_LOAD  = 4'h4,
    OP_RATIO_EN    = 4'h5,
    OP_RATIO_QUERY = 4'h6,
    OP_HOME_DIR    = 4'h7,
    OP_RESOLUTION  = 4'h8,
    OP_HOME        = 4'h9,
    OP_MOTION      = 4'ha
  } opcode_type;

  typedef enum logic [1:0] {
    RES_1   = 2'h0,
    RES_2   = 2'h1,
    RES_10  = 2'h2,
    RES_125 = 2'h3
  } resolution_type;

  typedef enum logic [1:0] {
    REPLY_POS   = 2'h0,
    REPLY_RATIO = 2'h1,
    REPLY_DONE  = 2'h2
  } reply_kind_type;

  typedef enum logic [0:0] {
    HOME_IDLE = 1'b0,
    HOME_SEEK = 1'b1
  } home_state_type;

  // One decoded host command
  typedef struct packed {
    opcode_type               op;
    logic                     axis;
    logic                     plus;
    logic [`CMD_VALUE_W-1:0]  value;
  } cmd_type;

  // One reply toward the host formatter
  typedef struct packed {
    reply_kind_type           kind;
    logic                     axis;
    logic [7:0]               status;
    logic [`POS_W-1:0]        value;
  } reply_type;
endpackage

// ==== tb/axis_position_props.sv ====
// Checker for the position block, bound to its top ports.
// Assumes the block's package and constant header come first.
`timescale 1ns/1ns
`include "axis_position_map.svh"

module axis_position_props
  import axis_position_pkg::*;
#(
  parameter logic [`TICK_COUNT_W-1:0] HOME_TICK_CYCLES =
    `TICK_COUNT_W'(`HOME_TICK_CYCLES)
) (
  input wire logic                   i_clock,
  input wire logic                   i_resetn,
  input wire logic                   i_cmd_valid,
  input wire cmd_type                i_cmd,
  input wire logic [`AXIS_COUNT-1:0] i_step_cw,
  input wire logic [`AXIS_COUNT-1:0] i_step_ccw,
  input wire logic [`AXIS_COUNT-1:0] i_moving,
  input wire logic [`AXIS_COUNT-1:0] i_moving_cw,
  input wire logic [`AXIS_COUNT-1:0] i_speed_mode,
  input wire logic [`AXIS_COUNT-1:0] i_move_done,
  input wire logic [`AXIS_COUNT-1:0] i_home_switch_input,
  input wire logic                   o_reply_valid,
  input wire reply_type              o_reply,
  input wire logic [`AXIS_COUNT-1:0] o_step_req,
  input wire logic [`AXIS_COUNT-1:0] o_step_cw,
  input wire logic [`AXIS_COUNT-1:0] o_homing,
  input wire logic [`AXIS_COUNT-1:0] o_underflow
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  ////////////////////////////////////////////////////////////////////////
  // Gap since the last homing step; the first step is free of the
  // divider phase, so only later steps are timed
  logic [`TICK_COUNT_W-1:0] gap_q;
  logic                     armed_q;
  always_ff @(posedge i_clock) begin
    if (!i_resetn || !o_homing[0]) begin
      gap_q   <= '0;
      armed_q <= 1'b0;
    end else if (o_step_req[0]) begin
      gap_q   <= `TICK_COUNT_W'(1);
      armed_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  query_reply_a: assert property (
    i_cmd_valid && i_cmd.op == OP_QUERY_POS |=> o_reply_valid &&
      o_reply.kind == REPLY_POS && o_reply.axis == $past(i_cmd.axis))
    else $error("position query lacks its reply");
  reply_status_a: assert property (
    i_cmd_valid && i_cmd.op == OP_QUERY_POS |=> o_reply.status ==
      (!$past(i_moving[i_cmd.axis]) ? `STATUS_STOPPED :
       $past(i_moving_cw[i_cmd.axis]) ? `STATUS_CW : `STATUS_CCW))
    else $error("reply status differs from motion at query");
  ratio_reply_a: assert property (
    i_cmd_valid && i_cmd.op == OP_RATIO_QUERY |=> o_reply_valid &&
      o_reply.kind == REPLY_RATIO)
    else $error("ratio query lacks its reply");
  reply_cause_a: assert property (
    o_reply_valid && o_reply.kind != REPLY_DONE |-> $past(i_cmd_valid))
    else $error("query reply without a command");
  home_start_a: assert property (
    i_cmd_valid && i_cmd.op == OP_HOME && !i_cmd.axis |=> o_homing[0])
    else $error("home command did not start homing");
  home_rate_a: assert property (
    o_step_req[0] && o_homing[0] && armed_q |-> gap_q == HOME_TICK_CYCLES)
    else $error("homing steps off the sample period");
  underflow_hold_a: assert property (
    o_underflow[1] && !o_homing[1] &&
      !(i_cmd_valid && i_cmd.op == OP_SET_POS && i_cmd.axis)
      |=> o_underflow[1])
    else $error("underflow flag dropped on its own");
  set_clear_a: assert property (
    i_cmd_valid && i_cmd.op == OP_SET_POS && i_cmd.axis |=> !o_underflow[1])
    else $error("position set left underflow standing");
endmodule

// ==== tb/host_model.sv ====
// Host side model: hands decoded commands to the block one at a time.
// Assumes callers enter send just after a rising clock edge.
`timescale 1ns/1ns

module host_model
  import axis_position_pkg::*;
(
  input  wire logic i_clock,
  output logic      o_cmd_valid,
  output cmd_type   o_cmd
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One command per two cycles; the idle bus shows junk so that
  // nothing can lean on a stale command
  task automatic send(input opcode_type op, input logic ax,
                      input logic plus, input logic [39:0] val);
    o_cmd_valid = 1'b1;
    o_cmd.op    = op;
    o_cmd.axis  = ax;
    o_cmd.plus  = plus;
    o_cmd.value = (op == OP_RATIO_LOAD) ? {8'h00, val[31:0]} : val;
    @(posedge i_clock);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd       = cmd_type'(~o_cmd);
    @(posedge i_clock);
    #1;
  endtask
endmodule

// ==== tb/axis_position_ratio_home_tb.sv ====
// Self-checking bench for the position, ratio and home block.
// Assumes the package, header, checker and host model compiled first.
`timescale 1ns/1ns
`include "axis_position_map.svh"

module axis_position_ratio_home_tb
  import axis_position_pkg::*;
;
  localparam logic [`TICK_COUNT_W-1:0] TICK = `TICK_COUNT_W'(8);
  typedef struct packed {
    opcode_type  op;
    logic        ax;
    logic [39:0] val;
    logic [31:0] exp;
  } row_type;
  logic       i_clock, i_resetn, i_cmd_valid, o_reply_valid, fdir;
  logic [1:0] i_step_cw, i_step_ccw, i_moving, i_moving_cw, i_speed_mode;
  logic [1:0] i_move_done, i_home_switch_input;
  logic [1:0] o_step_req, o_step_cw, o_homing, o_underflow;
  cmd_type    i_cmd;
  reply_type  o_reply, last_reply;
  int         mismatches = 0, n_tests = 0, n_replies = 0, fsteps = 0;
  // Ordinary set-then-read cases
  row_type rows [5] = '{
    '{OP_SET_POS, 1'b0, 40'h00_0000_0180, 32'h0000_0002},
    '{OP_SET_POS, 1'b1, 40'h00_0000_017f, 32'h0000_0001},
    '{OP_SET_POS, 1'b0, 40'hff_ffff_ff00, 32'hffff_ffff},
    '{OP_RATIO_LOAD, 1'b1, 40'h00_0c00_0000, 32'h0c00_0000},
    '{OP_RATIO_LOAD, 1'b0, 40'h00_8000_0000, 32'h8000_0000}};

  axis_position_ratio_home #(.HOME_TICK_CYCLES(TICK)) dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_step_cw(i_step_cw), .i_step_ccw(i_step_ccw),
    .i_moving(i_moving), .i_moving_cw(i_moving_cw),
    .i_speed_mode(i_speed_mode), .i_move_done(i_move_done),
    .i_home_switch_input(i_home_switch_input),
    .o_reply_valid(o_reply_valid), .o_reply(o_reply),
    .o_step_req(o_step_req), .o_step_cw(o_step_cw),
    .o_homing(o_homing), .o_underflow(o_underflow));
  host_model host (.i_clock(i_clock), .o_cmd_valid(i_cmd_valid),
    .o_cmd(i_cmd));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture replies and follower steps as they stand for one cycle
  always @(posedge i_clock) begin
    if (o_reply_valid === 1'b1) begin
      last_reply <= o_reply;
      n_replies  <= n_replies + 1;
    end
    if (o_step_req[1] === 1'b1) begin
      fsteps <= fsteps + 1;
      fdir   <= o_step_cw[1];
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // Query and compare; status only matters for position replies
  task automatic ask(input logic ax, input logic pos,
                     input logic [31:0] exp, input logic [7:0] st);
    int n;
    n = n_replies;
    host.send(pos ? OP_QUERY_POS : OP_RATIO_QUERY, ax, 1'b0, 40'h0);
    check(40'(n_replies - n), 40'h1);
    check({8'h00, last_reply.value}, {8'h00, exp});
    if (pos) check({32'h0, last_reply.status}, {32'h0, st});
  endtask

  // One step pulse, then a quiet cycle before the next
  task automatic step(input logic ax, input logic cw);
    i_step_cw[ax]  = cw;
    i_step_ccw[ax] = !cw;
    wait_cycles(1);
    i_step_cw  = '0;
    i_step_ccw = '0;
    wait_cycles(1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    {i_resetn, i_step_cw, i_step_ccw, i_moving, i_moving_cw} = '0;
    {i_speed_mode, i_move_done, i_home_switch_input} = '0;
    wait_cycles(20);
    i_resetn = 1'b1;
    check({38'h0, o_underflow}, 40'h0);
    ask(1'b0, 1'b1, 32'h0, `STATUS_STOPPED);
    foreach (rows[i]) begin
      host.send(rows[i].op, rows[i].ax, 1'b0, rows[i].val);
      ask(rows[i].ax, rows[i].op == OP_SET_POS, rows[i].exp, 8'h3d);
    end
    // Query in the same cycle as a step reports the earlier value
    host.send(OP_SET_POS, 1'b0, 1'b0, 40'h00_0010_0000);
    i_moving[0] = 1'b1;
    i_moving_cw[0] = 1'b1;
    step(1'b0, 1'b1);
    i_step_cw[0] = 1'b1;
    fork
      ask(1'b0, 1'b1, 32'h0000_1400, `STATUS_CW);
      begin
        wait_cycles(1);
        i_step_cw[0] = 1'b0;
      end
    join
    i_moving_cw[0] = 1'b0;
    ask(1'b0, 1'b1, 32'h0000_1800, `STATUS_CCW);
    step(1'b0, 1'b0);
    i_moving[0] = 1'b0;
    ask(1'b0, 1'b1, 32'h0000_1400, `STATUS_STOPPED);
    // Underflow floors at zero and clears on a position set
    host.send(OP_SET_POS, 1'b1, 1'b0, 40'h00_0001_0000);
    step(1'b1, 1'b0);
    check({38'h0, o_underflow}, 40'h2);
    ask(1'b1, 1'b1, 32'h0, `STATUS_STOPPED);
    host.send(OP_SET_POS, 1'b1, 1'b0, 40'h0);
    check({38'h0, o_underflow}, 40'h0);
    // Completion message only at move end, and none once disabled
    n = n_replies;
    host.send(OP_TRIGGER, 1'b0, 1'b1, 40'h0);
    wait_cycles(4);
    check(40'(n_replies - n), 40'h0);
    for (int k = 0; k < 2; k++) begin
      n = n_replies;
      i_move_done[0] = 1'b1;
      wait_cycles(1);
      i_move_done[0] = 1'b0;
      wait_cycles(4);
      check(40'(n_replies - n), k == 0 ? 40'h1 : 40'h0);
      check({38'h0, last_reply.kind}, {38'h0, REPLY_DONE});
      host.send(OP_TRIGGER, 1'b0, 1'b0, 40'h0);
    end
    // Half ratio: stored only, then following opposite, then ended
    host.send(OP_RATIO_LOAD, 1'b1, 1'b0, 40'h00_8000_0000);
    for (int k = 0; k < 3; k++) begin
      n = fsteps;
      if (k == 1) host.send(OP_RATIO_EN, 1'b1, 1'b0, 40'h0);
      if (k == 2) host.send(OP_MOTION, 1'b1, 1'b0, 40'h0);
      repeat (4) step(1'b0, 1'b1);
      wait_cycles(3);
      check(40'(fsteps - n), k == 1 ? 40'h2 : 40'h0);
    end
    check({39'h0, fdir}, 40'h0);
    // Ratio loaded mid-move waits for the move end, unless speed mode;
    // re-enabling reuses the kept half ratio
    host.send(OP_RATIO_EN, 1'b1, 1'b1, 40'h0);
    i_moving[0] = 1'b1;
    host.send(OP_RATIO_LOAD, 1'b1, 1'b0, 40'h0);
    ask(1'b1, 1'b0, 32'h0, 8'h3d);
    for (int k = 0; k < 3; k++) begin
      if (k == 1) begin
        i_move_done[0] = 1'b1;
        wait_cycles(1);
        i_move_done[0] = 1'b0;
      end
      if (k == 2) begin
        i_speed_mode[0] = 1'b1;
        host.send(OP_RATIO_LOAD, 1'b1, 1'b0, 40'h00_8000_0000);
      end
      n = fsteps;
      repeat (4) step(1'b0, 1'b1);
      wait_cycles(3);
      check(40'(fsteps - n), k == 1 ? 40'h0 : 40'h2);
    end
    check({39'h0, fdir}, 40'h1);
    {i_moving, i_speed_mode} = '0;
    host.send(OP_MOTION, 1'b1, 1'b0, 40'h0);
    // Final homing at 1/125 step per sample, both directions
    host.send(OP_RESOLUTION, 1'b0, 1'b0, 40'h3);
    for (int d = 1; d >= 0; d--) begin
      host.send(OP_SET_POS, 1'b0, 1'b0, 40'h00_0010_0000);
      host.send(OP_HOME_DIR, 1'b0, d[0], 40'h0);
      host.send(OP_HOME, 1'b0, 1'b0, 40'h0);
      for (int i = 0; i < 40 && o_step_req[0] !== 1'b1; i++) wait_cycles(1);
      check({39'h0, o_step_cw[0]}, {39'h0, d[0]});
      wait_cycles(1);
      ask(1'b0, 1'b1, d ? 32'h0000_1008 : 32'h0000_0ff8, 8'h3d);
      for (int i = 0; i < 40 && o_step_req[0] !== 1'b1; i++) wait_cycles(1);
      i_home_switch_input[0] = 1'b1;
      for (int i = 0; i < 40 && o_homing[0] !== 1'b0; i++) wait_cycles(1);
      i_home_switch_input[0] = 1'b0;
      ask(1'b0, 1'b1, 32'h0, `STATUS_STOPPED);
    end
    // Mid-run reset drops the sticky follower underflow and position
    check({38'h0, o_underflow}, 40'h2);
    i_resetn = 1'b0;
    wait_cycles(2);
    i_resetn = 1'b1;
    check({38'h0, o_underflow}, 40'h0);
    ask(1'b1, 1'b1, 32'h0, `STATUS_STOPPED);
    give_verdict();
  end

  // Whole run is near 250 cycles; sixteen times that means a hang
  initial begin
    repeat (4000) @(posedge i_clock);
    mismatches++;
    give_verdict();
  end
endmodule

bind axis_position_ratio_home axis_position_props #(
  .HOME_TICK_CYCLES(HOME_TICK_CYCLES)) props (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd), .i_step_cw(i_step_cw), .i_step_ccw(i_step_ccw),
  .i_moving(i_moving), .i_moving_cw(i_moving_cw),
  .i_speed_mode(i_speed_mode), .i_move_done(i_move_done),
  .i_home_switch_input(i_home_switch_input),
  .o_reply_valid(o_reply_valid), .o_reply(o_reply),
  .o_step_req(o_step_req), .o_step_cw(o_step_cw),
  .o_homing(o_homing), .o_underflow(o_underflow));
